//--- src/plwd_cfg.svh
// Purpose: constants of the program loop watchdog (offsets, fields, reset values, interval bases)
// Assumes: included by the top module and by the bench, bare name only
// Notes: offsets are peripheral byte addresses, 28 bits wide
`ifndef PLWD_CFG_SVH
`define PLWD_CFG_SVH

// ****************************************
// register map and reset values
// ****************************************
`define PLWD_MODE_OFS 28'hffff6d0
`define PLWD_KICK_OFS 28'hffff6d1
`define PLWD_MODE_RST 8'h67
`define PLWD_KICK_RD 8'h9a
`define PLWD_KICK_CODE 8'hac

// ****************************************
// field positions of the mode register
// ****************************************
`define PLWD_ACT_HI 6
`define PLWD_ACT_LO 5
`define PLWD_CS_HI 4
`define PLWD_CS_MID 3
`define PLWD_CS_K_HI 2

// ****************************************
// interval exponent bases per count source
// ****************************************
`define PLWD_EXP_INT 5'h0c
`define PLWD_EXP_MAIN 5'h12
`define PLWD_EXP_SUB 5'h09
`define PLWD_CNT_W 26

`endif

//--- src/plwd_pkg.sv
// Purpose: shared types of the program loop watchdog
// Assumes: plwd_cfg.svh holds the numbers
// Notes: bus words are bytes; addresses 28 bits
package plwd_pkg;
   typedef logic [27:0] plwd_addr_t;
   typedef logic [7:0] plwd_byte_t;
   // what an overflow does, decoded from mode bits 6:5
   typedef enum {PLWD_ACT_STOP, PLWD_ACT_NMI, PLWD_ACT_RESET} plwd_act_t;
   // state of one count-source synchroniser
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } plwd_sync_t;
endpackage : plwd_pkg

//--- src/plwd_src_sync.sv
// Purpose: bring one count-source clock into clk and give a pulse per rising edge
// Assumes: source runs well below half of clk
// Notes: first flop feeds only the second
module plwd_src_sync
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic src_in,
   output logic tick
);
   import plwd_pkg::*;

   plwd_sync_t st_r;
   plwd_sync_t st_nxt;

   // shift chain; edge detect looks only at the settled stages
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = src_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign tick = st_r.s2 & ~st_r.s3;
endmodule : plwd_src_sync

//--- src/plwd_top.sv
// Purpose: program loop watchdog with write-once mode register and kick register
// Assumes: peripheral bus gives one-cycle read/write strobes with byte and bit-op qualifiers
// Notes: overflow outputs are one-cycle pulses from flops; count sources are asynchronous pins
`include "plwd_cfg.svh"
module plwd_top
#(
   parameter int CNT_W = `PLWD_CNT_W
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire plwd_pkg::plwd_addr_t bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_byte,
   input wire logic bus_bitop,
   input wire plwd_pkg::plwd_byte_t bus_wdata,
   output plwd_pkg::plwd_byte_t bus_rdata,
   input wire logic int_osc_clk,
   input wire logic main_clk_src,
   input wire logic sub_clk_src,
   input wire logic osc_stab_active,
   output logic wd_reset_out,
   output logic wd_nmi_request,
   output logic cpu_clk_to_int_osc
);
   import plwd_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0] wd_mode_reg;
      logic written;
      logic [CNT_W-1:0] cnt;
      logic rst_pls;
      logic nmi_pls;
      logic sw_pls;
      logic [7:0] rdata;
   } plwd_state_t;

   plwd_state_t st_r;
   plwd_state_t st_nxt;

   logic tick_int;
   logic tick_main;
   logic tick_sub;
   logic tick;
   logic [4:0] exp_sel;
   logic [CNT_W-1:0] limit;
   logic [CNT_W-1:0] one;
   plwd_act_t act;
   logic mode_wr;
   logic kick_wr;
   logic kick_ok;
   logic expire;
   logic forced;
   logic ov;

   // ****************************************
   // count sources
   // ****************************************
   plwd_src_sync u_sync_int
   (
      .clk(clk),
      .reset_n(reset_n),
      .src_in(int_osc_clk),
      .tick(tick_int)
   );

   plwd_src_sync u_sync_main
   (
      .clk(clk),
      .reset_n(reset_n),
      .src_in(main_clk_src),
      .tick(tick_main)
   );

   plwd_src_sync u_sync_sub
   (
      .clk(clk),
      .reset_n(reset_n),
      .src_in(sub_clk_src),
      .tick(tick_sub)
   );

   // ****************************************
   // decode of mode, source and bus strobes
   // ****************************************
   always_comb
   begin
      one = {{(CNT_W-1){1'b0}}, 1'b1};
      // action follows the stored mode bits
      if (st_r.wd_mode_reg[`PLWD_ACT_HI])
         act = PLWD_ACT_RESET;
      else if (st_r.wd_mode_reg[`PLWD_ACT_LO])
         act = PLWD_ACT_NMI;
      else
         act = PLWD_ACT_STOP;
      // source and exponent base from the two top select bits
      case (st_r.wd_mode_reg[`PLWD_CS_HI:`PLWD_CS_MID])
         2'b00:
         begin
            tick = tick_int;
            exp_sel = `PLWD_EXP_INT + {2'b00, st_r.wd_mode_reg[`PLWD_CS_K_HI:0]};
         end
         2'b01:
         begin
            tick = tick_main;
            exp_sel = `PLWD_EXP_MAIN + {2'b00, st_r.wd_mode_reg[`PLWD_CS_K_HI:0]};
         end
         default:
         begin
            tick = tick_sub;
            exp_sel = `PLWD_EXP_SUB + {2'b00, st_r.wd_mode_reg[`PLWD_CS_K_HI:0]};
         end
      endcase
      limit = (one << exp_sel) - one;
      // bit-op writes to the mode register are not byte writes and are dropped
      mode_wr = bus_wr && bus_addr == `PLWD_MODE_OFS && bus_byte && !bus_bitop;
      kick_wr = bus_wr && bus_addr == `PLWD_KICK_OFS;
      kick_ok = kick_wr && bus_byte && !bus_bitop && bus_wdata == `PLWD_KICK_CODE;
      // a good kick or a mode write in the expiry cycle clears first, so no late overflow follows it
      expire = act != PLWD_ACT_STOP && tick && st_r.cnt == limit && !kick_ok && !mode_wr;
      // misuse counts only while running, so stop mode can never be tripped
      forced = act != PLWD_ACT_STOP && ((mode_wr && st_r.written) || (kick_wr && !kick_ok));
      ov = expire || forced;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rst_pls = 1'b0;
      st_nxt.nmi_pls = 1'b0;
      st_nxt.sw_pls = 1'b0;
      // only the first byte write lands; later writes leave the mode alone
      if (mode_wr && !st_r.written)
      begin
         st_nxt.wd_mode_reg = {1'b0, bus_wdata[6:0]};
         st_nxt.written = 1'b1;
      end
      // any clear beats a source tick in the same cycle
      if (act == PLWD_ACT_STOP || mode_wr || kick_ok || ov)
         st_nxt.cnt = '0;
      else if (tick)
         st_nxt.cnt = st_r.cnt + one;
      // overflow action; settling oscillator turns reset into a clock switch
      if (ov)
      begin
         if (act == PLWD_ACT_RESET)
         begin
            if (osc_stab_active)
               st_nxt.sw_pls = 1'b1;
            else
               st_nxt.rst_pls = 1'b1;
         end
         else
            st_nxt.nmi_pls = 1'b1;
      end
      // read data held until the next read
      if (bus_rd)
      begin
         case (bus_addr)
            `PLWD_MODE_OFS:
               st_nxt.rdata = st_r.wd_mode_reg;
            `PLWD_KICK_OFS:
               st_nxt.rdata = `PLWD_KICK_RD;
            default:
               st_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         st_r.wd_mode_reg <= `PLWD_MODE_RST;
         st_r.written <= 1'b0;
         st_r.cnt <= '0;
         st_r.rst_pls <= 1'b0;
         st_r.nmi_pls <= 1'b0;
         st_r.sw_pls <= 1'b0;
         st_r.rdata <= 8'h00;
      end
      else
         st_r <= st_nxt;
   end

   assign bus_rdata = st_r.rdata;
   assign wd_reset_out = st_r.rst_pls;
   assign wd_nmi_request = st_r.nmi_pls;
   assign cpu_clk_to_int_osc = st_r.sw_pls;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // mode stays at reset value until the first write
   property p_mode_reset;
      !st_r.written |-> st_r.wd_mode_reg == `PLWD_MODE_RST;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("mode not at reset value");

   // once written, further writes cannot move the mode
   property p_write_once;
      st_r.written && mode_wr |=> $stable(st_r.wd_mode_reg) ##1 $stable(st_r.wd_mode_reg);
   endproperty
   a_write_once: assert property (p_write_once) else $error("mode changed after first write");

   // kick register reads fixed code
   property p_kick_read;
      bus_rd && bus_addr == `PLWD_KICK_OFS |=> bus_rdata == `PLWD_KICK_RD;
   endproperty
   a_kick_read: assert property (p_kick_read) else $error("kick read value wrong");

   // good kick restarts counter with no overflow
   property p_kick_clear;
      kick_ok && !(mode_wr && st_r.written) |=> st_r.cnt == '0 && !wd_reset_out && !wd_nmi_request;
   endproperty
   a_kick_clear: assert property (p_kick_clear) else $error("kick did not restart");

   // wrong kick value while running gives an overflow pulse next cycle
   property p_bad_kick;
      kick_wr && bus_byte && !bus_bitop && bus_wdata != `PLWD_KICK_CODE && act != PLWD_ACT_STOP
         |=> (wd_reset_out || wd_nmi_request || cpu_clk_to_int_osc) && st_r.cnt == '0;
   endproperty
   a_bad_kick: assert property (p_bad_kick) else $error("bad kick missed");

   // bit access to kick register trips like a bad value
   property p_bitop_kick;
      kick_wr && bus_bitop && act != PLWD_ACT_STOP |=> wd_reset_out || wd_nmi_request || cpu_clk_to_int_osc;
   endproperty
   a_bitop_kick: assert property (p_bitop_kick) else $error("bit access to kick missed");

   // second mode write in nmi mode trips and clears
   property p_second_write;
      mode_wr && st_r.written && act == PLWD_ACT_NMI |=> wd_nmi_request && st_r.cnt == '0;
   endproperty
   a_second_write: assert property (p_second_write) else $error("second mode write missed");

   // stop mode never produces an output, whatever software writes
   property p_stop_quiet;
      act == PLWD_ACT_STOP |=> !wd_reset_out && !wd_nmi_request && !cpu_clk_to_int_osc;
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("output in stop mode");

   // nmi mode expiry gives nmi and never reset
   property p_nmi_expiry;
      expire && act == PLWD_ACT_NMI |=> wd_nmi_request && !wd_reset_out ##1 !wd_nmi_request;
   endproperty
   a_nmi_expiry: assert property (p_nmi_expiry) else $error("nmi expiry wrong");

   // reset mode overflow while oscillator settles switches clock, no reset
   property p_stab_switch;
      ov && act == PLWD_ACT_RESET && osc_stab_active |=> cpu_clk_to_int_osc && !wd_reset_out;
   endproperty
   a_stab_switch: assert property (p_stab_switch) else $error("settling overflow reset cpu");

   // reset mode expiry outside settling resets
   property p_reset_expiry;
      expire && act == PLWD_ACT_RESET && !osc_stab_active |=> wd_reset_out && st_r.cnt == '0;
   endproperty
   a_reset_expiry: assert property (p_reset_expiry) else $error("reset expiry missed");

   // main scenarios
   property p_cov_expire;
      expire ##1 wd_reset_out;
   endproperty
   c_cov_expire: cover property (p_cov_expire);

   property p_cov_kick;
      kick_ok ##1 st_r.cnt == '0;
   endproperty
   c_cov_kick: cover property (p_cov_kick);

   property p_cov_nmi;
      mode_wr && !st_r.written && bus_wdata[6:5] == 2'b01 ##[1:1000] wd_nmi_request;
   endproperty
   c_cov_nmi: cover property (p_cov_nmi);

   property p_cov_stop;
      mode_wr && !st_r.written && bus_wdata == 8'h00 ##1 kick_wr && !kick_ok;
   endproperty
   c_cov_stop: cover property (p_cov_stop);
endmodule : plwd_top

//--- bench/plwd_cpu_model.sv
// Purpose: cpu-side master of the watchdog register bus
// Assumes: tasks are entered at a falling clk edge, one access at a time
// Notes: released lines show the inverted last value, so a stale address never matches
module plwd_cpu_model
(
   input wire logic clk,
   output plwd_pkg::plwd_addr_t bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic bus_byte,
   output logic bus_bitop,
   output plwd_pkg::plwd_byte_t bus_wdata,
   input wire plwd_pkg::plwd_byte_t bus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import plwd_pkg::*;

   // idle bus at time zero
   initial
   begin
      bus_addr = 28'h0000000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_byte = 1'b1;
      bus_bitop = 1'b0;
      bus_wdata = 8'h00;
   end

   // write strobe held across exactly one rising edge, then released; returns on the falling edge
   // where an overflow pulse from this write stands
   task automatic wr(input plwd_addr_t a, input plwd_byte_t d, input logic byt, input logic bop);
      bus_addr = a;
      bus_wdata = d;
      bus_byte = byt;
      bus_bitop = bop;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask : wr

   // read data is taken one cycle after the strobe, where it has settled
   task automatic rd(input plwd_addr_t a, output plwd_byte_t d);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      bus_addr = ~a;
      @(negedge clk);
      d = bus_rdata;
   endtask : rd
endmodule : plwd_cpu_model

//--- bench/test_program_loop_watchdog.sv
// Purpose: self-checking bench of the program loop watchdog
// Assumes: inputs change at falling clk edges; sub clock period is 16 clk
// Notes: every mode test starts from a fresh reset, the mode being write-once
`include "plwd_cfg.svh"
`define PLWD_CHK(nm, exp, act) \
   begin \
      checked++; \
      if ((act) !== (exp)) \
      begin \
         err_count++; \
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, act); \
      end \
   end
module test_program_loop_watchdog;
   timeunit 1ns;
   timeprecision 1ps;
   import plwd_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic int_osc_clk = 1'b0;
   logic int_osc_stop = 1'b0;
   logic main_clk_src = 1'b0;
   logic sub_clk_src = 1'b0;
   logic osc_stab_active = 1'b0;
   plwd_addr_t bus_addr;
   plwd_byte_t bus_wdata, bus_rdata;
   logic bus_wr, bus_rd, bus_byte, bus_bitop;
   logic wd_reset_out, wd_nmi_request, cpu_clk_to_int_osc;
   int err_count = 0;
   int checked = 0;
   int seed = 32'h1313;

   // ****************************************
   // clocks: count sources toggle on falling clk edges
   // ****************************************
   always #2 clk = ~clk;
   always #36 if (!int_osc_stop) int_osc_clk = ~int_osc_clk;
   always #28 main_clk_src = ~main_clk_src;
   always #32 sub_clk_src = ~sub_clk_src;

   plwd_top i_dut (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_byte(bus_byte), .bus_bitop(bus_bitop), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .int_osc_clk(int_osc_clk), .main_clk_src(main_clk_src), .sub_clk_src(sub_clk_src),
      .osc_stab_active(osc_stab_active), .wd_reset_out(wd_reset_out), .wd_nmi_request(wd_nmi_request),
      .cpu_clk_to_int_osc(cpu_clk_to_int_osc));

   plwd_cpu_model i_cpu (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_byte(bus_byte), .bus_bitop(bus_bitop), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   // ****************************************
   // shared tasks
   // ****************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // reset held 16 cycles; released at a falling edge
   task automatic restart();
      reset_n = 1'b0;
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
   endtask : restart

   // counts one-cycle pulses over a bounded window, starting at the falling edge the caller stands on;
   // a pulse from a write shows only at the edge where the write task returns
   task automatic watch(input int n, input int er, input int en, input int eo);
      int cr, cn, co;
      cr = 0;
      cn = 0;
      co = 0;
      repeat (n)
      begin
         cr += (wd_reset_out === 1'b1);
         cn += (wd_nmi_request === 1'b1);
         co += (cpu_clk_to_int_osc === 1'b1);
         @(negedge clk);
      end
      `PLWD_CHK("reset pulses", er, cr)
      `PLWD_CHK("nmi pulses", en, cn)
      `PLWD_CHK("osc switch pulses", eo, co)
   endtask : watch

   // random bad kick code, never the valid one
   function automatic plwd_byte_t bad_code();
      plwd_byte_t v;
      v = $random(seed);
      return (v == 8'hac) ? 8'h00 : v;
   endfunction : bad_code

   // hard limit on run time, well above the expected length
   initial
   begin
      #380us;
      err_count++;
      complete_run();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      plwd_byte_t d;
      plwd_byte_t m;
      // defaults, refusals and forced overflows in the default reset mode
      restart();
      i_cpu.rd(`PLWD_MODE_OFS, d);
      `PLWD_CHK("mode reset", 8'h67, d)
      i_cpu.rd(`PLWD_KICK_OFS, d);
      `PLWD_CHK("kick reset", 8'h9a, d)
      i_cpu.rd(28'hffff6d2, d);
      `PLWD_CHK("unmapped", 8'h00, d)
      i_cpu.wr(`PLWD_MODE_OFS, 8'h30, 1'b0, 1'b0);
      watch(1, 0, 0, 0);
      i_cpu.rd(`PLWD_MODE_OFS, d);
      `PLWD_CHK("mode after halfword", 8'h67, d)
      i_cpu.wr(`PLWD_KICK_OFS, bad_code(), 1'b1, 1'b0);
      watch(4, 1, 0, 0);
      i_cpu.wr(`PLWD_KICK_OFS, 8'hac, 1'b1, 1'b1);
      watch(4, 1, 0, 0);
      osc_stab_active = 1'b1;
      i_cpu.wr(`PLWD_KICK_OFS, bad_code(), 1'b1, 1'b0);
      watch(4, 0, 0, 1);
      osc_stab_active = 1'b0;
      i_cpu.wr(`PLWD_KICK_OFS, 8'hac, 1'b1, 1'b0);
      watch(4, 0, 0, 0);
      i_cpu.rd(`PLWD_KICK_OFS, d);
      `PLWD_CHK("kick after write", 8'h9a, d)
      // nmi then reset mode on the subclock, k = 0: 512 ticks of 16 clk
      for (int i = 0; i < 2; i++)
      begin
         m = (i == 0) ? 8'h30 : 8'h70;
         restart();
         i_cpu.wr(`PLWD_MODE_OFS, m, 1'b1, 1'b0);
         watch(1, 0, 0, 0);
         i_cpu.rd(`PLWD_MODE_OFS, d);
         `PLWD_CHK("mode written", m, d)
         i_cpu.wr(`PLWD_MODE_OFS, 8'h00, 1'b1, 1'b0);
         watch(4, m[6], !m[6], 0);
         i_cpu.rd(`PLWD_MODE_OFS, d);
         `PLWD_CHK("mode kept", m, d)
         repeat (3)
         begin
            watch(6400, 0, 0, 0);
            i_cpu.wr(`PLWD_KICK_OFS, 8'hac, 1'b1, 1'b0);
         end
         watch(8150, 0, 0, 0);
         watch(120, m[6], !m[6], 0);
      end
      // stop mode on the subclock, then fully cleared with the internal oscillator halted:
      // no expiry and misuse ignored
      for (int i = 0; i < 2; i++)
      begin
         m = (i == 0) ? 8'h10 : 8'h00;
         restart();
         int_osc_stop = (i == 1);
         i_cpu.wr(`PLWD_MODE_OFS, m, 1'b1, 1'b0);
         watch(1, 0, 0, 0);
         i_cpu.wr(`PLWD_KICK_OFS, bad_code(), 1'b1, 1'b0);
         watch(4, 0, 0, 0);
         i_cpu.wr(`PLWD_MODE_OFS, 8'h70, 1'b1, 1'b0);
         watch(4, 0, 0, 0);
         i_cpu.rd(`PLWD_MODE_OFS, d);
         `PLWD_CHK("stop mode kept", m, d)
         watch(9000, 0, 0, 0);
      end
      complete_run();
   end
endmodule : test_program_loop_watchdog
